// File: verilog/adf_formatter.sv
`timescale 1ns/1ps
`include "adf_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Pattern 000 passes normal samples and flag
// - Pattern 001 drives all outputs low
// - Pattern 011 drives all outputs high
// - Pattern 101 alternates checkerboard and its complement
// - Pattern 111 alternates all zeros, all ones
// - Bit 2 turns polarity alternation on/off
// - Polarity alternation forces offset binary output
// - Bit 1 enables the output randomizer
// - Bit 0 selects offset binary or two's complement
// - Software reset clears format register to zero
module adf_formatter
	import adf_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       in_valid,
	output logic            in_ready,
	input  wire adf_pair_t  in_data,
	output logic            out_valid,
	input  wire logic       out_ready,
	output adf_pair_t       out_data
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		adf_fmt_t   fmt;
		adf_phase_t phase;
		logic       ovr1_seen;
		logic       ovr2_seen;
		logic [7:0] count;
		logic [7:0] rdata;
		logic       flush;
	} adf_top_st_t;

	adf_top_st_t st_r;
	adf_top_st_t st_nxt;

	// Only the format field of the reset byte, so the cast is width-exact
	localparam logic [7:0] FMT_RST_BYTE = `ADF_FMT_RESET;

	adf_pair_t   fmt_pair;
	logic        accept;
	logic        wr_reset;
	logic        wr_format;
	logic        wr_status;
	logic        sw_reset;
	logic [7:0]  fmt_rd;
	logic [7:0]  status_rd;
	logic [7:0]  rd_mux;
	logic        fifo_in_ready;
	logic        fifo_in_valid;

	////////////////////////////////////////////////////////////////////////////
	// Register decode

	assign wr_reset  = reg_wr && (reg_addr == `ADF_REG_RESET);
	assign wr_format = reg_wr && (reg_addr == `ADF_REG_FORMAT);
	assign wr_status = reg_wr && (reg_addr == `ADF_REG_STATUS);
	assign sw_reset  = wr_reset && reg_wdata[`ADF_SWRST_BIT];

	always_comb begin
		fmt_rd = `ADF_FMT_RESET;
		fmt_rd[`ADF_TP_HI:`ADF_TP_LO] = st_r.fmt.test_pattern_select;
		fmt_rd[`ADF_POL_BIT]          = st_r.fmt.alt_polarity_enable;
		fmt_rd[`ADF_SCRAM_BIT]        = st_r.fmt.scrambler_enable;
		fmt_rd[`ADF_TWOS_BIT]         = st_r.fmt.signed_format_select;
	end

	always_comb begin
		status_rd = '0;
		status_rd[`ADF_ST_PHASE_BIT] = (st_r.phase == ADF_PH_B);
		status_rd[`ADF_ST_FULL_BIT]  = !fifo_in_ready;
		status_rd[`ADF_ST_VALID_BIT] = out_valid;
		status_rd[`ADF_ST_OVR1_BIT]  = st_r.ovr1_seen;
		status_rd[`ADF_ST_OVR2_BIT]  = st_r.ovr2_seen;
	end

	always_comb begin
		case (reg_addr)
			`ADF_REG_FORMAT: rd_mux = fmt_rd;
			`ADF_REG_STATUS: rd_mux = status_rd;
			`ADF_REG_COUNT:  rd_mux = st_r.count;
			// Reset bit self-clears, so it always reads zero
			default:         rd_mux = `ADF_RDATA_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample path

	// Flush cycle after a software reset refuses input
	assign fifo_in_valid = in_valid && !st_r.flush;
	assign in_ready      = fifo_in_ready && !st_r.flush;
	assign accept        = fifo_in_valid && fifo_in_ready;

	adf_chan_fmt #(
		.DATA_W (16)
	) u_fmt_ch1 (
		.fmt      (st_r.fmt),
		.phase    (st_r.phase),
		.raw_ovr  (in_data.ch1.overrange_flag),
		.raw_data (in_data.ch1.sample_bits),
		.fmt_ovr  (fmt_pair.ch1.overrange_flag),
		.fmt_data (fmt_pair.ch1.sample_bits)
	);

	adf_chan_fmt #(
		.DATA_W (16)
	) u_fmt_ch2 (
		.fmt      (st_r.fmt),
		.phase    (st_r.phase),
		.raw_ovr  (in_data.ch2.overrange_flag),
		.raw_data (in_data.ch2.sample_bits),
		.fmt_ovr  (fmt_pair.ch2.overrange_flag),
		.fmt_data (fmt_pair.ch2.sample_bits)
	);

	// Downstream back-pressure stalls the converter side through in_ready
	adf_fifo #(
		.WIDTH ($bits(adf_pair_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.flush     (st_r.flush),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fmt_pair),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.flush = 1'b0;
		st_nxt.rdata = reg_rd ? rd_mux : `ADF_RDATA_IDLE;

		if (wr_format) begin
			st_nxt.fmt.test_pattern_select  = reg_wdata[`ADF_TP_HI:`ADF_TP_LO];
			st_nxt.fmt.alt_polarity_enable  = reg_wdata[`ADF_POL_BIT];
			st_nxt.fmt.scrambler_enable     = reg_wdata[`ADF_SCRAM_BIT];
			st_nxt.fmt.signed_format_select = reg_wdata[`ADF_TWOS_BIT];
		end

		if (accept) begin
			// Alternating patterns step once per sample accepted into the FIFO
			st_nxt.phase = (st_r.phase == ADF_PH_A) ? ADF_PH_B : ADF_PH_A;
			st_nxt.count = st_r.count + 8'h01;
		end

		// Sticky flags: a new overrange beats a write-one clear
		if (wr_status && reg_wdata[`ADF_ST_OVR1_BIT]) begin
			st_nxt.ovr1_seen = 1'b0;
		end
		if (wr_status && reg_wdata[`ADF_ST_OVR2_BIT]) begin
			st_nxt.ovr2_seen = 1'b0;
		end
		if (accept && in_data.ch1.overrange_flag) begin
			st_nxt.ovr1_seen = 1'b1;
		end
		if (accept && in_data.ch2.overrange_flag) begin
			st_nxt.ovr2_seen = 1'b1;
		end

		if (sw_reset) begin
			st_nxt.fmt       = adf_fmt_t'(FMT_RST_BYTE[`ADF_TP_HI:0]);
			st_nxt.phase     = ADF_PH_A;
			st_nxt.ovr1_seen = 1'b0;
			st_nxt.ovr2_seen = 1'b0;
			st_nxt.count     = `ADF_COUNT_RESET;
			st_nxt.flush     = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;

endmodule

// File: verilog/adf_consts.svh
`ifndef ADF_CONSTS_SVH
`define ADF_CONSTS_SVH

// Register offsets (byte addresses on the plain register port)
`define ADF_REG_RESET     8'h00
`define ADF_REG_FORMAT    8'h04
`define ADF_REG_STATUS    8'h08
`define ADF_REG_COUNT     8'h0c

// Reset register
`define ADF_SWRST_BIT     7

// Format register fields
`define ADF_TP_HI         5
`define ADF_TP_LO         3
`define ADF_POL_BIT       2
`define ADF_SCRAM_BIT     1
`define ADF_TWOS_BIT      0
`define ADF_FMT_RESET     8'h00

// Test pattern codes
`define ADF_TP_OFF        3'h0
`define ADF_TP_ZEROS      3'h1
`define ADF_TP_ONES       3'h3
`define ADF_TP_CHECKER    3'h5
`define ADF_TP_TOGGLE     3'h7

// Status register fields
`define ADF_ST_PHASE_BIT  0
`define ADF_ST_FULL_BIT   1
`define ADF_ST_VALID_BIT  2
`define ADF_ST_OVR1_BIT   4
`define ADF_ST_OVR2_BIT   5

`define ADF_COUNT_RESET   8'h00
`define ADF_RDATA_IDLE    8'h00

`endif

// File: verilog/adf_pkg.sv
package adf_pkg;

	typedef struct packed {
		logic        overrange_flag;
		logic [15:0] sample_bits;
	} adf_word_t;

	typedef struct packed {
		adf_word_t ch2;
		adf_word_t ch1;
	} adf_pair_t;

	typedef struct packed {
		logic [2:0] test_pattern_select;
		logic       alt_polarity_enable;
		logic       scrambler_enable;
		logic       signed_format_select;
	} adf_fmt_t;

	typedef enum logic {
		ADF_PH_A = 1'b0,
		ADF_PH_B = 1'b1
	} adf_phase_t;

endpackage

// File: verilog/adf_chan_fmt.sv
`timescale 1ns/1ps
`include "adf_consts.svh"

module adf_chan_fmt
	import adf_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input  wire adf_fmt_t          fmt,
	input  wire adf_phase_t        phase,
	input  wire logic              raw_ovr,
	input  wire logic [DATA_W-1:0] raw_data,
	output logic                   fmt_ovr,
	output logic [DATA_W-1:0]      fmt_data
);

	logic [DATA_W-1:0] coded;
	logic [DATA_W-1:0] chk_word;

	always_comb begin
		coded = raw_data;
		// Polarity alternation forces offset binary
		if (fmt.signed_format_select && !fmt.alt_polarity_enable) begin
			coded[DATA_W-1] = ~raw_data[DATA_W-1];
		end
		if (fmt.alt_polarity_enable) begin
			for (int i = 1; i < DATA_W; i += 2) begin
				coded[i] = ~coded[i];
			end
		end
		// LSB stays plain so the receiver can undo the scrambling
		if (fmt.scrambler_enable) begin
			for (int i = 1; i < DATA_W; i++) begin
				coded[i] = coded[i] ^ coded[0];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			chk_word[i] = (i % 2 == 0);
		end
	end

	always_comb begin
		case (fmt.test_pattern_select)
			`ADF_TP_OFF: begin
				fmt_ovr  = raw_ovr;
				fmt_data = coded;
			end
			`ADF_TP_ZEROS: begin
				fmt_ovr  = 1'b0;
				fmt_data = '0;
			end
			`ADF_TP_ONES: begin
				fmt_ovr  = 1'b1;
				fmt_data = '1;
			end
			`ADF_TP_CHECKER: begin
				fmt_ovr  = (phase == ADF_PH_A);
				fmt_data = (phase == ADF_PH_A) ? chk_word : ~chk_word;
			end
			`ADF_TP_TOGGLE: begin
				fmt_ovr  = (phase == ADF_PH_B);
				fmt_data = (phase == ADF_PH_B) ? '1 : '0;
			end
			default: begin
				// Undefined codes pass normal data through
				fmt_ovr  = raw_ovr;
				fmt_data = coded;
			end
		endcase
	end

endmodule

// File: verilog/adf_fifo.sv
`timescale 1ns/1ps

module adf_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
	} adf_fifo_st_t;

	adf_fifo_st_t st_r;
	adf_fifo_st_t st_nxt;
	logic         push;
	logic         pop;

	assign in_ready  = (st_r.count != FULL);
	assign out_valid = (st_r.count != '0);
	assign out_data  = st_r.mem[st_r.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr_ptr] = in_data;
			st_nxt.wr_ptr = (st_r.wr_ptr == LAST) ? '0 : st_r.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd_ptr = (st_r.rd_ptr == LAST) ? '0 : st_r.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'b10:   st_nxt.count = st_r.count + 1'b1;
			2'b01:   st_nxt.count = st_r.count - 1'b1;
			default: st_nxt.count = st_r.count;
		endcase
		if (flush) begin
			st_nxt.wr_ptr = '0;
			st_nxt.rd_ptr = '0;
			st_nxt.count  = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// File: testbench/adf_formatter_checker.sv
`timescale 1ns/1ps

module adf_fmt_checker
	import adf_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       in_valid,
	input wire logic       in_ready,
	input wire adf_pair_t  in_data,
	input wire logic       out_valid,
	input wire adf_pair_t  out_data
);
	logic [5:0] fmt_r;
	logic [5:0] fq_r;
	adf_word_t  w_r;
	logic       new_r;
	wire [15:0] ob = out_data.ch1.sample_bits;
	wire [15:0] ib = w_r.sample_bits;

	// Shadow of the format field; a take into an empty FIFO shows at the head next cycle
	always_ff @(posedge clk) begin
		if (sys_rst || (reg_wr && reg_addr == 8'h00 && reg_wdata[7]))
			fmt_r <= 6'h00;
		else if (reg_wr && reg_addr == 8'h04)
			fmt_r <= reg_wdata[5:0];
		fq_r <= fmt_r;
		w_r <= in_data.ch1;
		new_r <= in_valid && in_ready && !out_valid && !sys_rst;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_fmt_wr; reg_wr && reg_addr == 8'h04; endsequence
	sequence s_fmt_rd; reg_rd && reg_addr == 8'h04; endsequence
	sequence s_swrst; reg_wr && reg_addr == 8'h00 && reg_wdata[7]; endsequence

	////////////////////////////////////////
	a_fmt_readback: assert property (s_fmt_wr ##2 s_fmt_rd |=>
		reg_rdata == ($past(reg_wdata, 3) & 8'h3f)) else $error("format readback wrong");
	a_swrst_clear: assert property (s_swrst ##2 s_fmt_rd |=> reg_rdata == 8'h00)
		else $error("format not cleared");
	a_plain_pass: assert property (new_r && fq_r == 6'h00 |-> out_data.ch1 == w_r)
		else $error("normal data altered");
	a_zeros_fill: assert property (new_r && fq_r[5:3] == 3'h1 |-> out_data == '0)
		else $error("zeros pattern wrong");
	a_ones_fill: assert property (new_r && fq_r[5:3] == 3'h3 |-> out_data == '1)
		else $error("ones pattern wrong");
	a_checker_word: assert property (new_r && fq_r[5:3] == 3'h5 |->
		out_data.ch2 == out_data.ch1 && (out_data.ch1 == 17'h15555 || out_data.ch1 == 17'h0aaaa))
		else $error("checkerboard wrong");
	a_toggle_word: assert property (new_r && fq_r[5:3] == 3'h7 |->
		out_data == '0 || out_data == '1) else $error("alternating pattern wrong");
	a_twos_msb: assert property (new_r && fq_r == 6'h01 |-> ob == {~ib[15], ib[14:0]})
		else $error("signed coding wrong");
	a_polarity_offset: assert property (new_r && fq_r == 6'h05 |-> ob == (ib ^ 16'haaaa))
		else $error("polarity coding wrong");
	a_scramble_lsb: assert property (new_r && fq_r == 6'h02 |->
		ob == {ib[15:1] ^ {15{ib[0]}}, ib[0]}) else $error("randomizer wrong");
endmodule

bind adf_formatter adf_fmt_checker #(.FIFO_DEPTH(FIFO_DEPTH)) adf_fmt_checker_i (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
	.in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_data(out_data));

// File: testbench/adf_sink.sv
`timescale 1ns/1ps

module adf_sink
	import adf_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      sys_rst,
	input  wire logic      stall,
	input  wire logic      out_valid,
	output logic           out_ready,
	input  wire adf_pair_t out_data
);
	adf_pair_t q[$];

	// Capture side; stall lets the FIFO fill and hold
	always @(posedge clk) begin
		if (sys_rst) begin
			out_ready <= 1'b0;
			q.delete();
		end else begin
			out_ready <= !stall;
			if (out_valid && out_ready)
				q.push_back(out_data);
		end
	end
endmodule

// File: testbench/adf_formatter_tb_top.sv
`timescale 1ns/1ps

module adf_formatter_tb_top
	import adf_pkg::*;
;
	typedef struct {
		logic [7:0]  f;
		logic [16:0] e;
	} adf_row_t;

	logic      clk = 1'b0;
	logic      sys_rst = 1'b1;
	logic      reg_wr = 1'b0;
	logic      reg_rd = 1'b0;
	logic      in_valid = 1'b0;
	logic      stall = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic      in_ready;
	logic      out_valid;
	logic      out_ready;
	adf_pair_t in_data = {2{17'h18003}};
	adf_pair_t out_data;
	int        n_errors = 0;
	int        samples_checked = 0;
	int        k;
	// Row index is the sample count, so pattern phase is row parity
	adf_row_t  rows[10] = '{'{8'h00, 17'h18003}, '{8'h08, 17'h00000}, '{8'h28, 17'h15555},
		'{8'h38, 17'h1ffff}, '{8'h18, 17'h1ffff}, '{8'h01, 17'h10003}, '{8'h05, 17'h12aa9},
		'{8'h02, 17'h17ffd}, '{8'hc0, 17'h18003}, '{8'h07, 17'h1d557}};

	always #4 clk = ~clk;

	adf_formatter adf_formatter_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));
	adf_sink adf_sink_i (.clk(clk), .sys_rst(sys_rst), .stall(stall), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));

	////////////////////////////////////////
	task chk(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({26'h0, reg_rdata}, {26'h0, e});
	endtask

	task push(input int n);
		@(posedge clk);
		in_valid <= 1'b1;
		repeat (n) @(posedge clk);
		in_valid <= 1'b0;
	endtask

	task wait_q(input int n);
		for (k = 0; k < 40 && adf_sink_i.q.size() < n; k++)
			@(posedge clk);
	endtask

	task print_verdict;
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#20000;
		n_errors++;
		print_verdict;
	end

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h04, 8'h00);
		rd(8'h40, 8'h00);
		foreach (rows[i]) begin
			wr(8'h04, rows[i].f);
			rd(8'h04, rows[i].f & 8'h3f);
			push(1);
			wait_q(i + 1);
			chk(adf_sink_i.q[i], {2{rows[i].e}});
		end
		// Far side stalls: four back-to-back takes must fill the FIFO
		wr(8'h04, 8'h00);
		stall <= 1'b1;
		push(4);
		@(negedge clk);
		chk({33'h0, in_ready}, 34'h0);
		stall <= 1'b0;
		wait_q(14);
		chk(adf_sink_i.q[13], {2{17'h18003}});
		// Status: both overrange flags caught, phase back at A, FIFO drained
		rd(8'h08, 8'h30);
		rd(8'h0c, 8'h0e);
		wr(8'h08, 8'h10);
		rd(8'h08, 8'h20);
		// Both phases of each alternating pattern, phase A first
		wr(8'h04, 8'h28);
		push(2);
		wait_q(16);
		chk(adf_sink_i.q[14], {2{17'h15555}});
		chk(adf_sink_i.q[15], {2{17'h0aaaa}});
		wr(8'h04, 8'h38);
		push(2);
		wait_q(18);
		chk(adf_sink_i.q[16], 34'h0);
		chk(adf_sink_i.q[17], {2{17'h1ffff}});
		wr(8'h04, 8'h2d);
		wr(8'h00, 8'h80);
		// Flush cycle after the software reset refuses input
		@(negedge clk);
		chk({33'h0, in_ready}, 34'h0);
		rd(8'h04, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h08, 8'h00);
		print_verdict;
	end
endmodule
